// ### hdl/pixel_color_blend_stage.sv
// output-merge colour stage: clamps, blending, dithering and logic ops
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module pixel_color_blend_stage
  import blend_stage_pkg::*;
#(
  parameter int NUM_RT = 8,
  parameter int DROP_BITS = FRAC - OUT_FRAC_BITS
)(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire blend_stage_pkg::reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  // pixel write messages
  input wire logic in_valid,
  input wire blend_stage_pkg::msg_s in_msg,
  // merged colour towards the render target
  output logic out_valid,
  output blend_stage_pkg::pix_s out_pix
);
  import blend_stage_pkg::*;

  logic [31:0] ctrl_ff;
  comp_t clamp_lo_ff;
  comp_t clamp_hi_ff;
  pix_s const_ff;
  logic [15:0] dith_x_ff;
  logic [15:0] dith_y_ff;
  logic [31:0] count_ff;
  rt_cfg_s rt_ff [NUM_RT];
  logic [31:0] reg_rdata_ff;
  logic out_valid_ff;
  pix_s out_pix_ff;
  pix_s nxt_pix;
  rt_cfg_s cfg;
  logic [3:0] dith_val;

  function automatic comp_t comp_at(pix_s p, logic [1:0] ch);
    comp_at = p[32'(ch) * CW +: CW];
  endfunction : comp_at

  function automatic comp_t clamp(wide_t v, comp_t lo, comp_t hi);
    if (v < wide_t'(lo))
      clamp = lo;
    else if (v > wide_t'(hi))
      clamp = hi;
    else
      clamp = v[CW-1:0];
  endfunction : clamp

  function automatic comp_t fmt_lo(fmt_e f);
    case (f)
      fmt_unorm: fmt_lo = comp_t'(0);
      fmt_snorm: fmt_lo = -ONE;
      fmt_uint: fmt_lo = comp_t'(0);
      default: fmt_lo = COMP_MIN;
    endcase
  endfunction : fmt_lo

  function automatic comp_t fmt_hi(fmt_e f);
    case (f)
      fmt_unorm: fmt_hi = ONE;
      fmt_snorm: fmt_hi = ONE;
      default: fmt_hi = COMP_MAX;
    endcase
  endfunction : fmt_hi

  function automatic logic is_int(fmt_e f);
    is_int = (f == fmt_uint) || (f == fmt_sint);
  endfunction : is_int

  function automatic comp_t inv(comp_t v);
    inv = comp_t'(ONE - v);
  endfunction : inv

  // r,g,b use min(1 - dst alpha, src alpha); the alpha channel uses one
  function automatic comp_t factor(factor_e sel, logic [1:0] ch,
                                   pix_s s, pix_s s1, pix_s d, pix_s c);
    comp_t sc;
    comp_t s1c;
    comp_t dc;
    comp_t cc;
    sc = comp_at(s, ch);
    s1c = comp_at(s1, ch);
    dc = comp_at(d, ch);
    cc = comp_at(c, ch);
    case (sel)
      factor_zero: factor = comp_t'(0);
      factor_one: factor = ONE;
      factor_src_colour: factor = sc;
      factor_inv_src_colour: factor = inv(sc);
      factor_src_alpha: factor = s.a;
      factor_inv_src_alpha: factor = inv(s.a);
      factor_second_source_colour: factor = s1c;
      factor_inv_second_source_colour: factor = inv(s1c);
      factor_second_source_alpha: factor = s1.a;
      factor_inv_second_source_alpha: factor = inv(s1.a);
      factor_dst_colour: factor = dc;
      factor_inv_dst_colour: factor = inv(dc);
      factor_dst_alpha: factor = d.a;
      factor_inv_dst_alpha: factor = inv(d.a);
      factor_const_colour: factor = cc;
      factor_inv_const_colour: factor = inv(cc);
      factor_const_alpha: factor = c.a;
      factor_inv_const_alpha: factor = inv(c.a);
      factor_alpha_saturate:
        if (ch == 2'h3)
          factor = ONE;
        else if (inv(d.a) < s.a)
          factor = inv(d.a);
        else
          factor = s.a;
      default: factor = comp_t'(0);
    endcase
  endfunction : factor

  // products drop the low FRAC bits but keep full range before the result is clamped
  function automatic wide_t mul(comp_t a, comp_t b);
    wide_t p;
    p = wide_t'(a) * wide_t'(b);
    mul = p >>> FRAC;
  endfunction : mul

  assign cfg = rt_ff[in_msg.rt];

  // dither lookup, offset applied before the low bits pick the cell
  always_comb
  begin
    logic [15:0] px;
    logic [15:0] py;
    px = in_msg.x + dith_x_ff;
    py = in_msg.y + dith_y_ff;
    dith_val = DITHER_MATRIX[{py[1:0], px[1:0], 2'h0} +: 4];
  end

  always_comb
  begin
    comp_t s;
    comp_t d;
    comp_t c;
    comp_t sf;
    comp_t df;
    comp_t v;
    wide_t st;
    wide_t dt;
    wide_t bl;
    wide_t dv;
    factor_e sfs;
    factor_e dfs;
    blend_func_e fn;
    pix_s s_in;
    pix_s d_in;
    pix_s c_in;
    logic pre;
    logic [3:0] lf;
    s = '0;
    d = '0;
    c = '0;
    sf = '0;
    df = '0;
    v = '0;
    st = '0;
    dt = '0;
    bl = '0;
    dv = '0;
    sfs = factor_zero;
    dfs = factor_zero;
    fn = blend_func_sum;
    nxt_pix = '0;
    pre = ctrl_ff[CTRL_PRE_BIT];
    lf = ctrl_ff[CTRL_FUNC_LSB +: 4];
    s_in = in_msg.src;
    d_in = in_msg.dst;
    c_in = const_ff;
    if (!cfg.has_alpha)
      d_in.a = ONE;
    if (cfg.blend_en && pre)
    begin
      for (int k = 0; k < 4; k++)
      begin
        s_in[k*CW +: CW] = clamp(wide_t'(comp_at(in_msg.src, 2'(k))),
                                 clamp_lo_ff, clamp_hi_ff);
        d_in[k*CW +: CW] = clamp(wide_t'(comp_at(d_in, 2'(k))),
                                 clamp_lo_ff, clamp_hi_ff);
        c_in[k*CW +: CW] = clamp(wide_t'(comp_at(const_ff, 2'(k))),
                                 clamp_lo_ff, clamp_hi_ff);
      end
    end
    for (int k = 0; k < 4; k++)
    begin
      s = comp_at(s_in, 2'(k));
      d = comp_at(d_in, 2'(k));
      c = comp_at(c_in, 2'(k));
      if (k == 3 && ctrl_ff[CTRL_INDEP_BIT])
      begin
        sfs = cfg.src_alpha_fac;
        dfs = cfg.dst_alpha_fac;
        fn = cfg.alpha_func;
      end
      else
      begin
        sfs = cfg.src_fac;
        dfs = cfg.dst_fac;
        fn = cfg.func;
      end
      sf = factor(sfs, 2'(k), s_in, in_msg.src1, d_in, c_in);
      df = factor(dfs, 2'(k), s_in, in_msg.src1, d_in, c_in);
      st = mul(s, sf);
      dt = mul(d, df);
      case (fn)
        blend_func_sum: bl = st + dt;
        blend_func_src_minus_dst: bl = st - dt;
        blend_func_dst_minus_src: bl = dt - st;
        blend_func_minimum: bl = (st < dt) ? st : dt;
        blend_func_maximum: bl = (st > dt) ? st : dt;
        default: bl = st + dt;
      endcase
      if (cfg.blend_en)
      begin
        if (ctrl_ff[CTRL_POST_BIT])
          bl = wide_t'(clamp(bl, clamp_lo_ff, clamp_hi_ff));
        v = clamp(bl, fmt_lo(cfg.fmt), fmt_hi(cfg.fmt));
        if (k == 3 && !cfg.has_alpha)
          v = ONE;
      end
      else if (is_int(cfg.fmt))
        v = clamp(wide_t'(s), fmt_lo(cfg.fmt), fmt_hi(cfg.fmt));
      else if (pre)
        v = clamp(wide_t'(s), clamp_lo_ff, clamp_hi_ff);
      else
        v = s;
      if (ctrl_ff[CTRL_LOGIC_BIT])
      begin
        for (int b = 0; b < CW; b++)
          v[b] = lf[{v[b], d[b]}];
      end
      else if (cfg.dither_en && !is_int(cfg.fmt))
      begin
        // the dither nibble sits just below the lowest kept bit
        dv = (wide_t'(dith_val) <<< DROP_BITS) >>> 4;
        dv = wide_t'(v) + dv;
        v = clamp(dv, COMP_MIN, COMP_MAX);
        v[DROP_BITS-1:0] = '0;
      end
      nxt_pix[k*CW +: CW] = v;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_valid_ff <= 1'b0;
      out_pix_ff <= '0;
      count_ff <= '0;
    end
    else if (ce)
    begin
      out_valid_ff <= in_valid;
      if (in_valid)
      begin
        out_pix_ff <= nxt_pix;
        count_ff <= count_ff + 32'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= CTRL_RESET;
      clamp_lo_ff <= comp_t'(0);
      clamp_hi_ff <= ONE;
      const_ff <= '0;
      dith_x_ff <= '0;
      dith_y_ff <= '0;
    end
    else if (ce && reg_req.wr)
    begin
      case (reg_req.addr)
        REG_CTRL: ctrl_ff <= reg_req.wdata;
        REG_CLAMP:
        begin
          clamp_lo_ff <= reg_req.wdata[CW-1:0];
          clamp_hi_ff <= reg_req.wdata[HI_LSB +: CW];
        end
        REG_CONST_RG:
        begin
          const_ff.r <= reg_req.wdata[CW-1:0];
          const_ff.g <= reg_req.wdata[HI_LSB +: CW];
        end
        REG_CONST_BA:
        begin
          const_ff.b <= reg_req.wdata[CW-1:0];
          const_ff.a <= reg_req.wdata[HI_LSB +: CW];
        end
        REG_DITHER:
        begin
          dith_x_ff <= reg_req.wdata[15:0];
          dith_y_ff <= reg_req.wdata[DITHER_Y_LSB +: 16];
        end
        default: ;
      endcase
    end
  end

  for (genvar i = 0; i < NUM_RT; i++)
  begin : g_rt
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        rt_ff[i] <= '0;
      else if (ce && reg_req.wr && reg_req.addr == REG_RT_BASE + AW'(4 * i))
        rt_ff[i] <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata_ff <= '0;
    else if (ce)
    begin
      reg_rdata_ff <= '0;
      if (reg_req.rd)
      begin
        case (reg_req.addr)
          REG_CTRL: reg_rdata_ff <= ctrl_ff;
          REG_CLAMP: reg_rdata_ff <= {4'h0, clamp_hi_ff, 4'h0, clamp_lo_ff};
          REG_CONST_RG: reg_rdata_ff <= {4'h0, const_ff.g, 4'h0, const_ff.r};
          REG_CONST_BA: reg_rdata_ff <= {4'h0, const_ff.a, 4'h0, const_ff.b};
          REG_DITHER: reg_rdata_ff <= {dith_y_ff, dith_x_ff};
          REG_COUNT: reg_rdata_ff <= count_ff;
          default:
          begin
            for (int j = 0; j < NUM_RT; j++)
              if (reg_req.addr == REG_RT_BASE + AW'(4 * j))
                reg_rdata_ff <= rt_ff[j];
          end
        endcase
      end
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign out_valid = out_valid_ff;
  assign out_pix = out_pix_ff;

  logic quiet_path;
  assign quiet_path = ce && in_valid && !ctrl_ff[CTRL_LOGIC_BIT]
                      && !cfg.dither_en;

  bypass_pass_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    quiet_path && !cfg.blend_en && !ctrl_ff[CTRL_PRE_BIT]
    && cfg.fmt == fmt_float |=> out_valid && out_pix == $past(in_msg.src))
    else $error("unblended pixel was altered");

  pre_clamp_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    quiet_path && !cfg.blend_en && ctrl_ff[CTRL_PRE_BIT]
    && cfg.fmt == fmt_float
    |=> out_pix.r >= $past(clamp_lo_ff) && out_pix.r <= $past(clamp_hi_ff))
    else $error("source left outside clamp range");

  int_clamp_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    quiet_path && !cfg.blend_en && cfg.fmt == fmt_uint
    |=> out_pix.g >= 0)
    else $error("unsigned target got negative value");

  post_clamp_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    quiet_path && cfg.blend_en && ctrl_ff[CTRL_POST_BIT]
    && cfg.fmt == fmt_float
    |=> out_pix.b >= $past(clamp_lo_ff) && out_pix.b <= $past(clamp_hi_ff))
    else $error("blend output outside clamp range");

  fmt_clamp_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    quiet_path && cfg.blend_en && cfg.fmt == fmt_unorm
    |=> out_pix.r >= 0 && out_pix.r <= ONE)
    else $error("blend output outside unorm range");

  no_alpha_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    quiet_path && cfg.blend_en && !cfg.has_alpha |=> out_pix.a == ONE)
    else $error("alpha produced without alpha channel");

  logic_set_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && in_valid && ctrl_ff[CTRL_LOGIC_BIT]
    && ctrl_ff[CTRL_FUNC_LSB +: 4] == logic_all_one
    |=> out_pix.r == comp_t'(-1) && out_pix.a == comp_t'(-1))
    else $error("set operation not all ones");

  dither_trunc_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && in_valid && !ctrl_ff[CTRL_LOGIC_BIT] && cfg.dither_en
    && !is_int(cfg.fmt) |=> out_pix.g[DROP_BITS-1:0] == '0)
    else $error("dithered value not truncated");

endmodule : pixel_color_blend_stage
`default_nettype wire

// ### hdl/blend_stage_pkg.sv
// constants, types and register map of the colour blend stage
// Operation
// - blend off, clamp on: clamp source to range
// - integer formats: clamp implicitly to format range
// - blend on, clamp on: clamp src, dst, constant
// - blend off bypasses blending and post clamp
// - factored source and destination combined by function
// - no alpha channel: destination alpha one, none output
// - independent alpha off: colour settings drive alpha
// - blend settings chosen by message target index
// - full set of blend factors and inverses
// - alpha saturate: min(1-dst alpha, src alpha), alpha one
// - function: sum, differences, minimum or maximum
// - post clamp only while blending, to clamp range
// - blending always clamps to format range
// - four-bit dither value from 4x4 matrix
// - offset coordinates, low two bits pick column, row
// - shift dither, add, truncate to buffer width
// - logic stage off passes pixels unchanged
// - logic ops on blendable and integer targets
// - sixteen bitwise source/destination operations
package blend_stage_pkg;
  localparam int CW = 12;
  localparam int FRAC = 8;
  localparam int WW = 2 * CW + 2;
  localparam int RT_IDX_W = 3;
  localparam int AW = 8;
  typedef logic signed [CW-1:0] comp_t;
  typedef logic signed [WW-1:0] wide_t;
  localparam comp_t ONE = 12'sh100;
  localparam comp_t COMP_MAX = 12'sh7ff;
  localparam comp_t COMP_MIN = -12'sh800;
  typedef struct packed {comp_t a; comp_t b; comp_t g; comp_t r;} pix_s;
  typedef struct packed {
    pix_s src;
    pix_s src1;
    pix_s dst;
    logic [15:0] x;
    logic [15:0] y;
    logic [RT_IDX_W-1:0] rt;
  } msg_s;
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  typedef enum logic [4:0] {
    factor_zero, factor_one, factor_src_colour, factor_inv_src_colour,
    factor_src_alpha, factor_inv_src_alpha, factor_second_source_colour,
    factor_inv_second_source_colour, factor_second_source_alpha,
    factor_inv_second_source_alpha, factor_dst_colour,
    factor_inv_dst_colour, factor_dst_alpha, factor_inv_dst_alpha,
    factor_const_colour, factor_inv_const_colour, factor_const_alpha,
    factor_inv_const_alpha, factor_alpha_saturate
  } factor_e;
  typedef enum logic [2:0] {
    blend_func_sum, blend_func_src_minus_dst, blend_func_dst_minus_src,
    blend_func_minimum, blend_func_maximum
  } blend_func_e;
  typedef enum logic [2:0] {
    fmt_unorm, fmt_snorm, fmt_float, fmt_uint, fmt_sint
  } fmt_e;
  // encoding equals truth table indexed by {source bit, destination bit}
  typedef enum logic [3:0] {
    logic_all_zero, logic_nor, logic_notsrc_and_dst, logic_not_source,
    logic_src_and_notdst, logic_not_destination, logic_xor, logic_nand,
    logic_and, logic_xnor, logic_keep_destination, logic_notsrc_or_dst,
    logic_pass_source, logic_src_or_notdst, logic_or, logic_all_one
  } logic_func_e;
  typedef struct packed {
    logic dither_en;
    blend_func_e alpha_func;
    factor_e dst_alpha_fac;
    factor_e src_alpha_fac;
    blend_func_e func;
    factor_e dst_fac;
    factor_e src_fac;
    logic has_alpha;
    fmt_e fmt;
    logic blend_en;
  } rt_cfg_s;
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_CLAMP = 8'h04;
  localparam logic [AW-1:0] REG_CONST_RG = 8'h08;
  localparam logic [AW-1:0] REG_CONST_BA = 8'h0c;
  localparam logic [AW-1:0] REG_DITHER = 8'h10;
  localparam logic [AW-1:0] REG_COUNT = 8'h14;
  localparam logic [AW-1:0] REG_RT_BASE = 8'h20;
  localparam int CTRL_PRE_BIT = 0;
  localparam int CTRL_POST_BIT = 1;
  localparam int CTRL_INDEP_BIT = 2;
  localparam int CTRL_LOGIC_BIT = 3;
  localparam int CTRL_FUNC_LSB = 4;
  localparam int HI_LSB = 16;
  localparam int DITHER_Y_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int OUT_FRAC_BITS = 5;
  localparam logic [63:0] DITHER_MATRIX = 64'h5d7f_91b3_c4e6_082a;
endpackage : blend_stage_pkg

// ### test/pixel_source_model.sv
// partner model: shader write messages carrying render target colour
`timescale 1ns/10ps
`default_nettype none
module pixel_source_model (
  // clock
  input wire logic clk,
  // message stream towards the blend stage
  output logic in_valid,
  output blend_stage_pkg::msg_s in_msg
);
  import blend_stage_pkg::*;

  initial
  begin
    in_valid = 1'b0;
    in_msg = '0;
  end

  // every message carries a second output, so second-source factors
  // are always legal here
  task automatic send(input msg_s m);
    @(posedge clk);
    in_valid <= 1'b1;
    in_msg <= m;
    @(posedge clk);
    in_valid <= 1'b0;
    // released bus shows inverted data so a stale value never matches
    in_msg <= msg_s'(~m);
  endtask : send
endmodule : pixel_source_model
`default_nettype wire

// ### test/pixel_color_blend_stage_tb.sv
// self-checking bench for the colour blend stage
`timescale 1ns/10ps
`default_nettype none
module pixel_color_blend_stage_tb;
  import blend_stage_pkg::*;
  localparam comp_t LS = 12'sh0c0;
  localparam comp_t LD = 12'sh0a0;
  logic clk, rst_n, ce, in_valid, out_valid;
  reg_req_s reg_req;
  logic [31:0] reg_rdata;
  msg_s in_msg;
  pix_s out_pix;
  logic [15:0] gx, gy;
  logic [47:0] gm;
  int bad_count, checks_done, sent, cycles;
  comp_t fexp[5] = '{12'sh0c0, -12'sh040, 12'sh040, 12'sh040, 12'sh080};
  int ftab[19] = '{0, 8, 4, 4, 4, 4, 6, 2, 6, 2, 2, 6, 2, 6, 1, 7, 1, 7, 4};

  pixel_color_blend_stage pixel_color_blend_stage_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .in_valid(in_valid), .in_msg(in_msg),
    .out_valid(out_valid), .out_pix(out_pix));
  pixel_source_model pixel_source_model_inst (
    .clk(clk), .in_valid(in_valid), .in_msg(in_msg));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    chk({16'h0, reg_rdata}, {16'h0, exp});
  endtask : rd

  function automatic pix_s mk(input comp_t v);
    return '{a: v, b: v, g: v, r: v};
  endfunction : mk

  function automatic logic [31:0] cfg(input logic be, input fmt_e f,
      input logic ha, input factor_e sf, input factor_e df,
      input blend_func_e fn, input logic dt);
    rt_cfg_s c;
    c = '{dither_en: dt, alpha_func: fn, dst_alpha_fac: df,
      src_alpha_fac: sf, func: fn, dst_fac: df, src_fac: sf,
      has_alpha: ha, fmt: f, blend_en: be};
    return c;
  endfunction : cfg

  function automatic comp_t lop(input logic [3:0] f);
    comp_t r;
    for (int b = 0; b < CW; b++)
      r[b] = f[{LS[b], LD[b]}];
    return r;
  endfunction : lop

  // one pixel through the stage, compared under the mask gm
  task automatic pc(input pix_s s, input pix_s d, input logic [2:0] rt,
      input pix_s e);
    int n;
    n = 0;
    pixel_source_model_inst.send('{src: s, src1: mk(12'sh0c0), dst: d,
      x: gx, y: gy, rt: rt});
    sent++;
    #1;
    while (out_valid !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({47'h0, out_valid}, 48'h1);
    chk(out_pix & gm, e & gm);
  endtask : pc

  initial
  begin
    pix_s s, e;
    logic [31:0] c;
    logic [3:0] idx;
    rst_n = 1'b0;
    ce = 1'b1;
    reg_req = '0;
    gx = '0;
    gy = '0;
    gm = '1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_CTRL, CTRL_RESET);
    rd(REG_CLAMP, 32'h0100_0000);
    rd(REG_COUNT, 32'h0);
    rd(8'h1c, 32'h0);
    wr(REG_CLAMP, 32'h00c0_0040);
    rd(REG_CLAMP, 32'h00c0_0040);
    $display("test registers done");
    // blend off: the pre-blend clamp acts on float targets, the format clamp on integer ones
    s = '{a: 12'sh100, b: 12'sh080, g: -12'sh040, r: 12'sh180};
    wr(REG_RT_BASE, cfg(1'b0, fmt_float, 1'b1, factor_one, factor_zero,
      blend_func_sum, 1'b0));
    pc(s, mk(12'sh020), 3'd0, '{a: 12'sh0c0, b: 12'sh080, g: 12'sh040,
      r: 12'sh0c0});
    wr(REG_CTRL, 32'h0);
    pc(s, mk(12'sh020), 3'd0, s);
    wr(REG_CTRL, 32'h1);
    wr(REG_RT_BASE + 8'h0c, cfg(1'b0, fmt_uint, 1'b1, factor_one,
      factor_zero, blend_func_sum, 1'b0));
    pc(s, mk(12'sh020), 3'd3, '{a: 12'sh100, b: 12'sh080, g: 12'sh000,
      r: 12'sh180});
    wr(REG_RT_BASE + 8'h1c, cfg(1'b0, fmt_sint, 1'b1, factor_one,
      factor_zero, blend_func_sum, 1'b0));
    pc(s, mk(12'sh020), 3'd7, s);
    $display("test pre-blend clamp done");
    wr(REG_CTRL, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(REG_RT_BASE + 8'h04, cfg(1'b1, fmt_float, 1'b1, factor_one,
        factor_one, blend_func_e'(i), 1'b0));
      pc(mk(12'sh040), mk(12'sh080), 3'd1,
        mk(fexp[i]));
    end
    wr(REG_CONST_RG, 32'h0020_0020);
    wr(REG_CONST_BA, 32'h0020_0020);
    for (int i = 0; i < 19; i++)
    begin
      wr(REG_RT_BASE + 8'h04, cfg(1'b1, fmt_float, 1'b1, factor_e'(i),
        factor_zero, blend_func_sum, 1'b0));
      e = mk(comp_t'(ftab[i] * 16));
      if (i == 18)
        e.a = 12'sh080;
      pc(mk(12'sh080), mk(12'sh040), 3'd1, e);
    end
    $display("test factors and functions done");
    wr(REG_CLAMP, 32'h0100_0000);
    wr(REG_CTRL, 32'h2);
    wr(REG_RT_BASE + 8'h04, cfg(1'b1, fmt_float, 1'b1, factor_one,
      factor_one, blend_func_sum, 1'b0));
    pc(mk(12'sh0c0), mk(12'sh0c0), 3'd1, mk(12'sh100));
    pc(s, mk(12'sh0c0), 3'd0, s);
    wr(REG_CTRL, 32'h0);
    pc(mk(12'sh0c0), mk(12'sh0c0), 3'd1, mk(12'sh180));
    wr(REG_RT_BASE + 8'h10, cfg(1'b1, fmt_unorm, 1'b1, factor_one,
      factor_one, blend_func_sum, 1'b0));
    pc(mk(12'sh0c0), mk(12'sh0c0), 3'd4, mk(12'sh100));
    wr(REG_RT_BASE + 8'h18, cfg(1'b1, fmt_snorm, 1'b1, factor_one,
      factor_one, blend_func_sum, 1'b0));
    pc(mk(-12'sh0c0), mk(-12'sh0c0), 3'd6, mk(-12'sh100));
    wr(REG_CLAMP, 32'h0080_0000);
    wr(REG_CTRL, 32'h1);
    pc(mk(12'sh0c0), mk(12'sh0c0), 3'd1, mk(12'sh100));
    $display("test clamps done");
    wr(REG_CTRL, 32'h0);
    wr(REG_RT_BASE + 8'h14, cfg(1'b1, fmt_float, 1'b0, factor_zero,
      factor_dst_alpha, blend_func_sum, 1'b0));
    e = mk(12'sh040);
    e.a = 12'sh100;
    pc(mk(12'sh080), mk(12'sh040), 3'd5, e);
    c = cfg(1'b1, fmt_float, 1'b1, factor_one, factor_zero,
      blend_func_sum, 1'b0);
    c[27:18] = {factor_one, factor_zero};
    wr(REG_RT_BASE + 8'h04, c);
    pc(mk(12'sh080), mk(12'sh040), 3'd1, mk(12'sh080));
    wr(REG_CTRL, 32'h4);
    e = mk(12'sh080);
    e.a = 12'sh040;
    pc(mk(12'sh080), mk(12'sh040), 3'd1, e);
    $display("test alpha handling done");
    wr(REG_CTRL, 32'h0);
    wr(REG_DITHER, 32'h0002_0001);
    wr(REG_RT_BASE + 8'h08, cfg(1'b0, fmt_float, 1'b1, factor_one,
      factor_zero, blend_func_sum, 1'b1));
    // only red is compared: the low three bits of 0x44 decide the carry
    gm = 48'h0fff;
    for (int i = 0; i < 16; i++)
    begin
      gx = 16'(i % 4) + 16'h0100;
      gy = 16'(i / 4) + 16'h0200;
      idx = {2'(gy + 16'h2), 2'(gx + 16'h1)};
      e = mk(DITHER_MATRIX[int'(idx) * 4 + 3] ? 12'sh048 : 12'sh040);
      pc(mk(12'sh044), mk(12'sh0), 3'd2,
        e);
    end
    gm = '1;
    gx = '0;
    gy = '0;
    $display("test dither done");
    // blending stays off while logic ops run
    for (int i = 0; i < 16; i++)
    begin
      wr(REG_CTRL, (32'(i) << 4) | 32'h8);
      pc(mk(LS), mk(LD), 3'd3, mk(lop(4'(i))));
    end
    wr(REG_RT_BASE + 8'h10, cfg(1'b0, fmt_unorm, 1'b1, factor_one,
      factor_zero, blend_func_sum, 1'b0));
    wr(REG_CTRL, 32'h68);
    pc(mk(LS), mk(LD), 3'd4, mk(12'sh060));
    $display("test logic ops done");
    // a write while the enable is low must leave the register alone
    ce <= 1'b0;
    wr(REG_DITHER, 32'hffff_ffff);
    ce <= 1'b1;
    rd(REG_DITHER, 32'h0002_0001);
    rd(REG_COUNT, 32'(sent));
    $display("test count done");
    stop_test();
  end
endmodule : pixel_color_blend_stage_tb
`default_nettype wire
